// ===== watchdog_with_halt_control_tb.sv
/* watchdog_with_halt_control_tb: self-checking bench of wwhc_top.
 * Assumes short prescaler periods and that the bench is the only bus master. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("Error %s expected %h seen %h", nm, e, g); end end
`define WAITS(c, lim) for (n = 0; n < lim && !(c); n++) @(posedge mclk);
module watchdog_with_halt_control_tb import wwhc_pkg::*;;
	logic mclk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, rdPhase = 1'h0, longDly = 1'h0;
	logic hwOpt = 1'h0, hrOpt = 1'h0, extIrq = 1'h0, extRst = 1'h0, haltReq = 1'h0, intMask = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ex, mk;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] v;
	logic hready, hreadyout, hresp, mcuReset, timebaseIrq, haltMode, activeHaltMode;
	logic [63:0] expQ[$];
	int err_total = 0, cmp_count = 0, n;
	assign hready = hreadyout;
	wwhc_top #(.WDG_PERIOD(16), .TB_PERIOD0(20), .TB_PERIOD1(40), .TB_PERIOD2(100), .TB_PERIOD3(250)) dut (
		.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .hwWatchdogOpt(hwOpt), .haltResetOpt(hrOpt), .longWakeDelay(longDly),
		.extIrq(extIrq), .extResetReq(extRst), .haltReq(haltReq), .cpuIntMask(intMask),
		.mcuReset(mcuReset), .timebaseIrq(timebaseIrq), .haltMode(haltMode), .activeHaltMode(activeHaltMode));
	// clock of 100 ns
	initial forever #50 mclk = ~mclk;
	// one single transfer; reads note the masked expectation
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d, input logic [31:0] m);
		@(posedge mclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		do @(posedge mclk); while (!hready);
		hsel <= 1'h0;
		htrans <= 2'h0;
		if (wr) hwdata <= d;
		else expQ.push_back({d, m});
		do @(posedge mclk); while (!hready);
	endtask : bus
	// one-cycle halt request
	task automatic pulseHalt;
		@(posedge mclk);
		haltReq <= 1'h1;
		@(posedge mclk);
		haltReq <= 1'h0;
	endtask : pulseHalt
	// reset with the given straps
	task automatic restart(input logic hw, input logic hr, input logic ld);
		rstn <= 1'h0;
		hwOpt <= hw;
		hrOpt <= hr;
		longDly <= ld;
		repeat (6) @(posedge mclk);
		rstn <= 1'h1;
		repeat (6) @(posedge mclk);
	endtask : restart
	task automatic conclude;
		$display("comparisons %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	// checks each completed read against the oldest note
	always @(posedge mclk) begin
		if (rdPhase && hready) begin
			{ex, mk} = expQ.pop_front();
			`CHK("hrdata", ex, hrdata & mk)
		end
		if (hready) rdPhase = hsel && htrans[1] && !hwrite;
	end
	// cuts a hang short
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		conclude();
	end
	// main sequence
	initial begin
		void'($urandom(64526));
		restart(1'h0, 1'h0, 1'($urandom % 2));
		bus(1'h0, WWHC_IDX_CTRL, 32'h7F, 32'hFF);
		bus(1'h0, 8'h00, 32'h0, 32'hFFFFFFFF);
		`WAITS(mcuReset, 1100)
		`CHK("mcuReset", 1'h0, mcuReset)
		bus(1'h0, WWHC_IDX_CTRL, 32'h0, 32'hC0);
		v = 8'hC0 | 8'($urandom % 6);
		bus(1'h1, WWHC_IDX_CTRL, {24'h0, v}, 32'h0);
		bus(1'h1, WWHC_IDX_CTRL, {24'h0, v & 8'h7F}, 32'h0);
		bus(1'h0, WWHC_IDX_CTRL, 32'h80, 32'h80);
		`WAITS(mcuReset, 200)
		`CHK("mcuReset", 1'h1, mcuReset)
		`WAITS(!mcuReset, 400)
		bus(1'h0, WWHC_IDX_CTRL, 32'h40, 32'hC0);
		bus(1'h1, WWHC_IDX_CTRL, 32'hA0, 32'h0);
		`WAITS(mcuReset, 5)
		`CHK("mcuReset", 1'h1, mcuReset)
		`WAITS(!mcuReset, 400)
		// full halt: one decrement, then the count stands
		bus(1'h1, WWHC_IDX_CTRL, 32'h7F, 32'h0);
		pulseHalt();
		repeat (200) @(posedge mclk);
		`CHK("haltMode", 1'h1, haltMode)
		bus(1'h0, WWHC_IDX_CTRL, 32'h7C, 32'h7C);
		extIrq <= 1'h1;
		repeat (4) @(posedge mclk);
		extIrq <= 1'h0;
		`WAITS(!haltMode, 10)
		`CHK("haltMode", 1'h0, haltMode)
		bus(1'h0, WWHC_IDX_STAT, 32'h4, 32'h4);
		repeat (longDly ? WWHC_DELAY_LONG : WWHC_DELAY_SHORT) @(posedge mclk);
		bus(1'h0, WWHC_IDX_STAT, 32'h0, 32'h4);
		// reset pin ends a halt and leaves the watchdog disabled
		bus(1'h1, WWHC_IDX_CTRL, 32'hFF, 32'h0);
		pulseHalt();
		repeat (10) @(posedge mclk);
		`CHK("haltMode", 1'h1, haltMode)
		extRst <= 1'h1;
		repeat (4) @(posedge mclk);
		extRst <= 1'h0;
		`WAITS(!haltMode, 10)
		bus(1'h0, WWHC_IDX_CTRL, 32'h40, 32'hC0);
		// active-halt held while masked, left once unmasked
		bus(1'h1, WWHC_IDX_TB, 32'h2, 32'h0);
		intMask <= 1'h1;
		pulseHalt();
		repeat (60) @(posedge mclk);
		`CHK("activeHaltMode", 1'h1, activeHaltMode)
		`CHK("timebaseIrq", 1'h0, timebaseIrq)
		intMask <= 1'h0;
		`WAITS(!activeHaltMode, 5)
		`CHK("activeHaltMode", 1'h0, activeHaltMode)
		bus(1'h0, WWHC_IDX_TB, 32'h3, 32'h3);
		// reset pin ends active-halt into the wake delay
		intMask <= 1'h1;
		pulseHalt();
		extRst <= 1'h1;
		repeat (4) @(posedge mclk);
		extRst <= 1'h0;
		bus(1'h0, WWHC_IDX_STAT, 32'h4, 32'h6);
		intMask <= 1'h0;
		// halt with the reset option strapped
		restart(1'h0, 1'h1, 1'h0);
		pulseHalt();
		`WAITS(mcuReset, 10)
		`CHK("mcuReset", 1'h1, mcuReset)
		`CHK("haltMode", 1'h0, haltMode)
		`WAITS(!mcuReset, 400)
		// hardware option: active without any write
		restart(1'h1, 1'h0, 1'h1);
		bus(1'h0, WWHC_IDX_STAT, 32'h8, 32'h8);
		`WAITS(mcuReset, 1200)
		`CHK("mcuReset", 1'h1, mcuReset)
		conclude();
	end
endmodule : watchdog_with_halt_control_tb

// ===== wwhc_divider.sv
/*
 * wwhc_divider: enable-gated prescaler giving a one-cycle tick every PERIOD enabled cycles.
 * Assumes PERIOD of at least 2; the phase is never cleared except by reset.
 */
`timescale 1ns/1ps
module wwhc_divider #(
	parameter int PERIOD = 16384,
	parameter int WIDTH = $clog2(PERIOD)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// control and tick
	input wire logic en,
	output logic tick
);

	localparam logic [WIDTH-1:0] LAST = WIDTH'(PERIOD - 1);

	logic [WIDTH-1:0] cnt_r;

	// count enabled cycles, wrap at the last one
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cnt_r <= '0;
		end else if (en) begin
			cnt_r <= (cnt_r == LAST) ? '0 : WIDTH'(cnt_r + 1'b1);
		end
	end

	// tick in the last enabled cycle of each period
	assign tick = en && (cnt_r == LAST);

endmodule : wwhc_divider

// ===== wwhc_pkg.sv
/*
 * wwhc_pkg: shared constants, register layout and types of the watchdog with halt control.
 * Assumes a 10 MHz oscillator clock (100 ns) and 32-bit AHB-Lite register access.
 */
package wwhc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] WWHC_IDX_CTRL = 8'h2A;
	localparam logic [7:0] WWHC_IDX_TB = 8'h2C;
	localparam logic [7:0] WWHC_IDX_STAT = 8'h2E;

	// watchdog control register fields and reset value
	localparam int WWHC_ACT_BIT = 7;
	localparam int WWHC_TOP_BIT = 6;
	localparam logic [7:0] WWHC_CTRL_RESET = 8'h7F;
	localparam logic [6:0] WWHC_ROLL_FROM = 7'h40;

	// timebase register fields
	localparam int WWHC_TB_FLAG_BIT = 0;
	localparam int WWHC_TB_TIE_BIT = 1;
	localparam int WWHC_TB_SEL_LSB = 2;
	localparam logic [1:0] WWHC_TB_SEL_RESET = 2'h0;

	// status register fields
	localparam int WWHC_ST_HALT_BIT = 0;
	localparam int WWHC_ST_AHALT_BIT = 1;
	localparam int WWHC_ST_DELAY_BIT = 2;
	localparam int WWHC_ST_HWOPT_BIT = 3;
	localparam int WWHC_ST_HROPT_BIT = 4;
	localparam int WWHC_ST_WDRST_BIT = 5;

	// prescaler periods in oscillator cycles
	localparam int WWHC_WDG_PRESCALE = 16384;
	localparam int WWHC_TB_PRESCALE0 = 16000;
	localparam int WWHC_TB_PRESCALE1 = 32000;
	localparam int WWHC_TB_PRESCALE2 = 80000;
	localparam int WWHC_TB_PRESCALE3 = 200000;
	localparam int WWHC_TB_WIDTH = 18;

	// timing: clock period, reset pulse, wake-up delays
	localparam int WWHC_CLK_PERIOD_NS = 100;
	localparam int WWHC_RST_PULSE_NS = 30000;
	localparam int WWHC_RST_CYCLES = (WWHC_RST_PULSE_NS + WWHC_CLK_PERIOD_NS - 1) / WWHC_CLK_PERIOD_NS;
	localparam int WWHC_DELAY_SHORT = 256;
	localparam int WWHC_DELAY_LONG = 4096;
	localparam int WWHC_SEQ_WIDTH = 12;

	// watchdog control register contents
	typedef struct packed {
		logic act;
		logic [6:0] cnt;
	} wwhc_ctrl_t;

	// timebase control contents
	typedef struct packed {
		logic [1:0] sel;
		logic tie;
		logic flag;
	} wwhc_tb_t;

	// power and reset sequencing states
	typedef enum logic [2:0] {
		WWHC_RUN,
		WWHC_HALT_ONCE,
		WWHC_HALT_STOP,
		WWHC_ACT_HALT,
		WWHC_WAKE_DLY,
		WWHC_RST_PULSE
	} wwhc_state_t;

endpackage : wwhc_pkg

// ===== wwhc_properties.sv
/* wwhc_properties: port-level timing checks of the watchdog top.
 * Assumes one mclk domain, rstn active low, one slave on the bus. */
`timescale 1ns/1ps
module wwhc_properties import wwhc_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	// pins and cpu side
	input wire logic extIrq,
	input wire logic cpuIntMask,
	input wire logic mcuReset,
	input wire logic timebaseIrq,
	input wire logic haltMode,
	input wire logic activeHaltMode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic ctrlWr_r;
	int rstLen_r;
	// marks the data phase of a control register write
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) ctrlWr_r <= 1'h0;
		else if (hready) ctrlWr_r <= hsel && htrans[1] && hwrite && haddr == 32'h000000A8;
	end
	// counts how long the reset pulse has stood
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) rstLen_r <= 0;
		else rstLen_r <= mcuReset ? rstLen_r + 1 : 0;
	end
	a_rst_pulse_len: assert property ($fell(mcuReset) |-> rstLen_r == WWHC_RST_CYCLES)
		else $error("reset pulse length wrong");
	a_sw_reset_now: assert property (ctrlWr_r && hready && hwdata[7] && !hwdata[6] |-> ##[1:3] mcuReset)
		else $error("software reset missing");
	a_halt_no_rst: assert property (haltMode |-> !mcuReset)
		else $error("reset while halted");
	a_halt_kinds_excl: assert property (!(haltMode && activeHaltMode))
		else $error("both halt modes at once");
	a_irq_mask_gate: assert property (timebaseIrq |-> !$past(cpuIntMask))
		else $error("interrupt while masked");
	a_irq_ends_ahalt: assert property (activeHaltMode && timebaseIrq |-> ##[0:3] !activeHaltMode)
		else $error("interrupt did not end active-halt");
	a_ext_ends_halt: assert property ($rose(extIrq) && haltMode |-> ##[1:8] !haltMode)
		else $error("external interrupt did not end halt");
	a_rst_not_halt: assert property ($rose(mcuReset) |-> !haltMode && !activeHaltMode)
		else $error("reset raised from a halt mode");
	a_read_one_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	c_reset: cover property ($rose(mcuReset));
	c_halt: cover property ($rose(haltMode));
	c_ahalt: cover property ($fell(activeHaltMode));
endmodule : wwhc_properties

bind wwhc_top wwhc_properties u_props (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.extIrq(extIrq), .cpuIntMask(cpuIntMask), .mcuReset(mcuReset), .timebaseIrq(timebaseIrq),
	.haltMode(haltMode), .activeHaltMode(activeHaltMode));

// ===== wwhc_top.sv
/*
 * wwhc_top: watchdog down-counter with halt and active-halt control, timebase and AHB-Lite registers.
 * Assumes mclk is the oscillator clock and also the CPU clock; haltReq and cpuIntMask come from
 * logic on mclk, the option straps and external interrupt/reset requests come from pins.
 */
// The AHB-Lite register port was decided locally.
// Overview of operation
// (R01) counter decrements every 16384 oscillator cycles
// (R02) rollover 40h to 3Fh while active resets
// (R03) activation bit set by software, reset clears
// (R04) no watchdog reset while inactive; keeps counting
// (R05) control register resets to 7Fh
// (R06) bits six to zero hold live count
// (R07) hardware option keeps watchdog always active
// (R08) halt without options: decrement once, stop
// (R09) interrupt ends halt: resume after delay
// (R10) reset ends halt: watchdog back disabled
// (R11) halt with reset option generates reset
// (R12) timebase enable: active-halt freezes counter
// (R13) reset ends active-halt: resume after delay
// (R14) software refreshes counter before halting
// (R15) timeout set by prescaler and count setting
// (R16) timebase enable selects active-halt on halt
// (R17) timebase interrupt gated, wakes active-halt only
// (R18) full halt freezes timebase counter, registers
// (R19) counter runs even while activation clear
// (R20) write active with top bit clear resets
// (R21) write loads count immediately, sets activation
`timescale 1ns/1ps
module wwhc_top import wwhc_pkg::*; #(
	parameter int WDG_PERIOD = WWHC_WDG_PRESCALE,
	parameter int TB_PERIOD0 = WWHC_TB_PRESCALE0,
	parameter int TB_PERIOD1 = WWHC_TB_PRESCALE1,
	parameter int TB_PERIOD2 = WWHC_TB_PRESCALE2,
	parameter int TB_PERIOD3 = WWHC_TB_PRESCALE3
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// option straps and external pins
	input wire logic hwWatchdogOpt,
	input wire logic haltResetOpt,
	input wire logic longWakeDelay,
	input wire logic extIrq,
	input wire logic extResetReq,
	// cpu side
	input wire logic haltReq,
	input wire logic cpuIntMask,
	output logic mcuReset,
	output logic timebaseIrq,
	output logic haltMode,
	output logic activeHaltMode
);

	localparam int NSYNC = 5;
	logic [1:0] rstSync_r;
	logic rstnSync;
	wire logic [NSYNC-1:0] pinRaw = {extResetReq, extIrq, longWakeDelay, haltResetOpt, hwWatchdogOpt};
	logic [NSYNC-1:0] pinMeta_r;
	logic [NSYNC-1:0] pinSync_r;
	logic [1:0] pinLast_r;
	logic [1:0] optAge_r;
	logic hwOpt_r, haltRstOpt_r, longDly_r;
	logic extIrqRise, extRstRise;
	wwhc_state_t state_r;
	logic [WWHC_SEQ_WIDTH-1:0] seq_r;
	wwhc_ctrl_t ctrl_r;
	wwhc_tb_t tb_r;
	logic [WWHC_TB_WIDTH-1:0] tbCnt_r;
	logic [1:0] tbSelLive_r;
	logic [WWHC_TB_WIDTH-1:0] tbLast;
	logic tbRun, tbOvf, tbWake;
	logic wdRun, wdTick, wdActive, rollover;
	logic dpValid_r, dpWrite_r, rdWait_r;
	logic [31:0] dpAddr_r;
	logic [31:0] hrdata_r;
	logic wdRstSeen_r;
	logic mcuReset_r, tbIrq_r, haltMode_r, aHalt_r;
	logic addrPhase, wrEn, wrCtrl, wrTb, rdTbClr, swTrig, haltRstFire, wdFire, reinit, seqDone;

	// decode of a byte address against a register index
	function automatic logic regHit(input logic [31:0] addr, input logic [7:0] idx);
		regHit = (addr == {22'h0, idx, 2'h0});
	endfunction : regHit

	// reset release through two flip-flops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end
	assign rstnSync = rstSync_r[1];

	// two-flop synchronisers for each pin input
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : gSync
			always_ff @(posedge mclk or negedge rstnSync) begin
				if (!rstnSync) begin
					pinMeta_r[gi] <= 1'b0;
					pinSync_r[gi] <= 1'b0;
				end else begin
					pinMeta_r[gi] <= pinRaw[gi];
					pinSync_r[gi] <= pinMeta_r[gi];
				end
			end
		end
	endgenerate

	// edge detection on synchronised interrupt and reset requests
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			pinLast_r <= 2'h0;
		end else begin
			pinLast_r <= pinSync_r[4:3];
		end
	end
	assign extIrqRise = pinSync_r[3] && !pinLast_r[0];
	assign extRstRise = pinSync_r[4] && !pinLast_r[1];

	// option straps followed for three cycles after release; the last one sees a settled synchroniser
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			optAge_r <= 2'h0;
			hwOpt_r <= 1'b0;
			haltRstOpt_r <= 1'b0;
			longDly_r <= 1'b0;
		end else if (optAge_r != 2'h3) begin
			optAge_r <= 2'(optAge_r + 1'b1);
			hwOpt_r <= pinSync_r[0];
			haltRstOpt_r <= pinSync_r[1];
			longDly_r <= pinSync_r[2];
		end
	end

	// bus address and data phase bookkeeping; reads take one wait state
	assign addrPhase = hsel && htrans[1] && hready;
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			dpValid_r <= 1'b0;
			dpWrite_r <= 1'b0;
			dpAddr_r <= 32'h0;
			rdWait_r <= 1'b0;
		end else begin
			if (hready) begin
				dpValid_r <= addrPhase;
				dpWrite_r <= hwrite;
				dpAddr_r <= haddr;
			end
			rdWait_r <= addrPhase && !hwrite;
		end
	end
	assign hreadyout = !rdWait_r;
	assign hresp = 1'b0;
	assign wrEn = dpValid_r && dpWrite_r && !rdWait_r;
	assign wrCtrl = wrEn && regHit(dpAddr_r, WWHC_IDX_CTRL);
	assign wrTb = wrEn && regHit(dpAddr_r, WWHC_IDX_TB);
	assign rdTbClr = rdWait_r && regHit(dpAddr_r, WWHC_IDX_TB);

	// read data registered at the end of the wait state; unmapped reads give zero
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			hrdata_r <= 32'h0;
		end else if (rdWait_r) begin
			if (regHit(dpAddr_r, WWHC_IDX_CTRL)) begin
				hrdata_r <= {24'h0, ctrl_r}; // R06
			end else if (regHit(dpAddr_r, WWHC_IDX_TB)) begin
				hrdata_r <= {28'h0, tb_r};
			end else if (regHit(dpAddr_r, WWHC_IDX_STAT)) begin
				hrdata_r <= {26'h0, wdRstSeen_r, haltRstOpt_r, hwOpt_r, state_r == WWHC_WAKE_DLY,
					state_r == WWHC_ACT_HALT, state_r == WWHC_HALT_ONCE || state_r == WWHC_HALT_STOP};
			end else begin
				hrdata_r <= 32'h0;
			end
		end
	end
	assign hrdata = hrdata_r;

	// watchdog prescaler, phase hidden from software and never cleared by writes
	assign wdRun = (state_r == WWHC_RUN) || (state_r == WWHC_HALT_ONCE); // R08 R12
	wwhc_divider #(
		.PERIOD(WDG_PERIOD)
	) uPrescaler (
		.clk(mclk),
		.rstN(rstnSync),
		.en(wdRun),
		.tick(wdTick)
	); // R01 R15

	// reset causes
	assign wdActive = ctrl_r.act || hwOpt_r; // R04 R07
	assign rollover = wdTick && (ctrl_r.cnt == WWHC_ROLL_FROM);
	assign swTrig = wrCtrl && (hwdata[WWHC_ACT_BIT] || wdActive) && !hwdata[WWHC_TOP_BIT]; // R20
	assign haltRstFire = haltReq && !tb_r.tie && haltRstOpt_r; // R11
	assign wdFire = (state_r == WWHC_RUN) && ((rollover && wdActive) || swTrig || haltRstFire); // R02 R04
	assign seqDone = (seq_r == '0);
	assign reinit = (state_r == WWHC_RST_PULSE) ? seqDone : extRstRise; // R10

	// power and reset sequencing
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			state_r <= WWHC_RUN;
			seq_r <= '0;
		end else begin
			case (state_r)
				WWHC_RUN: begin
					if (wdFire) begin
						state_r <= WWHC_RST_PULSE;
						seq_r <= WWHC_SEQ_WIDTH'(WWHC_RST_CYCLES - 1);
					end else if (haltReq && !extRstRise) begin
						state_r <= tb_r.tie ? WWHC_ACT_HALT : WWHC_HALT_ONCE; // R12 R16
					end
				end
				WWHC_HALT_ONCE, WWHC_HALT_STOP: begin
					if (extRstRise) begin
						state_r <= WWHC_RUN; // R10
					end else if (extIrqRise) begin
						state_r <= WWHC_WAKE_DLY; // R09
						seq_r <= longDly_r ? WWHC_SEQ_WIDTH'(WWHC_DELAY_LONG - 1) : WWHC_SEQ_WIDTH'(WWHC_DELAY_SHORT - 1);
					end else if (wdTick) begin
						state_r <= WWHC_HALT_STOP; // R08
					end
				end
				WWHC_ACT_HALT: begin
					if (extRstRise) begin
						state_r <= WWHC_WAKE_DLY; // R13
						seq_r <= longDly_r ? WWHC_SEQ_WIDTH'(WWHC_DELAY_LONG - 1) : WWHC_SEQ_WIDTH'(WWHC_DELAY_SHORT - 1);
					end else if (extIrqRise || tbWake) begin
						state_r <= WWHC_RUN; // R12 R17
					end
				end
				WWHC_WAKE_DLY: begin
					if (seqDone) begin
						state_r <= WWHC_RUN;
					end else begin
						seq_r <= WWHC_SEQ_WIDTH'(seq_r - 1'b1);
					end
				end
				WWHC_RST_PULSE: begin
					if (seqDone) begin
						state_r <= WWHC_RUN;
					end else begin
						seq_r <= WWHC_SEQ_WIDTH'(seq_r - 1'b1);
					end
				end
				default: begin
					state_r <= WWHC_RUN;
				end
			endcase
		end
	end

	// watchdog control register: reload, count, activation latch
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			ctrl_r <= WWHC_CTRL_RESET; // R05
		end else if (reinit) begin
			ctrl_r <= WWHC_CTRL_RESET; // R03 R10
		end else if (wrCtrl) begin
			ctrl_r.act <= ctrl_r.act || hwdata[WWHC_ACT_BIT]; // R03 R21
			ctrl_r.cnt <= hwdata[WWHC_TOP_BIT:0]; // R21
		end else if (wdTick) begin
			ctrl_r.cnt <= 7'(ctrl_r.cnt - 1'b1); // R01 R19
		end
	end

	// sticky mark of a reset issued by this block, kept until power-on reset
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			wdRstSeen_r <= 1'b0;
		end else if (wdFire) begin
			wdRstSeen_r <= 1'b1;
		end
	end

	// timebase period for the live selection
	always_comb begin
		case (tbSelLive_r)
			2'h0: tbLast = WWHC_TB_WIDTH'(TB_PERIOD0 - 1);
			2'h1: tbLast = WWHC_TB_WIDTH'(TB_PERIOD1 - 1);
			2'h2: tbLast = WWHC_TB_WIDTH'(TB_PERIOD2 - 1);
			default: tbLast = WWHC_TB_WIDTH'(TB_PERIOD3 - 1);
		endcase
	end

	// timebase counter frozen in full halt; new selection applies at period end
	assign tbRun = (state_r != WWHC_HALT_ONCE) && (state_r != WWHC_HALT_STOP) && (state_r != WWHC_RST_PULSE); // R18
	assign tbOvf = tbRun && (tbCnt_r == tbLast);
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			tbCnt_r <= '0;
			tbSelLive_r <= WWHC_TB_SEL_RESET;
		end else if (reinit) begin
			tbCnt_r <= '0;
			tbSelLive_r <= WWHC_TB_SEL_RESET;
		end else if (tbOvf) begin
			tbCnt_r <= '0;
			tbSelLive_r <= tb_r.sel;
		end else if (tbRun) begin
			tbCnt_r <= WWHC_TB_WIDTH'(tbCnt_r + 1'b1);
		end
	end

	// timebase control; overflow set wins over the read clear
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			tb_r <= '0;
		end else if (reinit) begin
			tb_r <= '0;
		end else begin
			if (wrTb) begin
				tb_r.sel <= hwdata[WWHC_TB_SEL_LSB +: 2];
				tb_r.tie <= hwdata[WWHC_TB_TIE_BIT];
			end
			if (tbOvf) begin
				tb_r.flag <= 1'b1;
			end else if (rdTbClr) begin
				tb_r.flag <= 1'b0;
			end
		end
	end

	// timebase interrupt and its wake of active-halt
	assign tbWake = tb_r.flag && tb_r.tie && !cpuIntMask; // R17

	// registered outputs
	always_ff @(posedge mclk or negedge rstnSync) begin
		if (!rstnSync) begin
			mcuReset_r <= 1'b0;
			tbIrq_r <= 1'b0;
			haltMode_r <= 1'b0;
			aHalt_r <= 1'b0;
		end else begin
			mcuReset_r <= wdFire || ((state_r == WWHC_RST_PULSE) && !seqDone);
			tbIrq_r <= tbWake;
			haltMode_r <= (state_r == WWHC_HALT_ONCE) || (state_r == WWHC_HALT_STOP);
			aHalt_r <= (state_r == WWHC_ACT_HALT);
		end
	end
	assign mcuReset = mcuReset_r;
	assign timebaseIrq = tbIrq_r;
	assign haltMode = haltMode_r;
	assign activeHaltMode = aHalt_r;

endmodule : wwhc_top
